// ==== rtl/ssw_ctrl.sv ====
// Function
// - low detect input selects secondary supply
// - high or floating input selects primary supply
// - status bit reads detect input inverted
// - two-bit field picks interrupt trigger edges
// - key 0xAA alone disables switch function; here it only blocks the reset request, supply select and flag keep working
// - enabled rising edge resets after delay, only while fast_internal_osc_on is high
// - switch function has own interrupt flag
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module ssw_ctrl (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  // axi4-lite write address
  input  wire logic [ssw_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // axi4-lite write data
  input  wire logic [ssw_pkg::AXI_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read address
  input  wire logic [ssw_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // axi4-lite read data
  output logic [ssw_pkg::AXI_DW-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // pins and system status
  input  wire logic                        field_detect_in,
  input  wire logic                        fast_internal_osc_on,
  // supply control and events
  output logic                             sel_secondary_supply,
  output logic                             field_detect_pullup_en,
  output logic                             mcu_reset_req,
  output logic                             pwr_sw_irq_flag
);
  import ssw_pkg::*;

  localparam int RST_CYC_WAIT = RST_DELAY_CYC; // edges from first count edge to the pulse

  // one-hot register decode: edge, key, pin, flag
  function automatic logic [3:0] ssw_decode(input logic [AXI_AW-1:0] addr);
    logic [3:0] hit;
    hit    = 4'h0;
    hit[0] = (addr == OFS_EDGE);
    hit[1] = (addr == OFS_KEY);
    hit[2] = (addr == OFS_PIN);
    hit[3] = (addr == OFS_FLAG);
    return hit;
  endfunction : ssw_decode

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_q1_reg;
  logic rst_n;

  // two-stage release of the async reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_q1_reg <= 1'b1;
      rst_n      <= rst_q1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [1:0]        edge_sel_reg;
  logic [7:0]        switch_key_reg;
  logic              detect_level_inv_reg;
  logic              flag_reg;
  logic              sel_sec_reg;
  logic              pullup_reg;
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [AXI_DW-1:0] wdata_reg;
  logic              wstrb0_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [AXI_DW-1:0] rdata_reg;
  ssw_dly_state_t    dly_state_reg;
  logic [DLY_W-1:0]  dly_cnt_reg;
  logic              wr_fire;
  logic [3:0]        wr_hit;
  logic [3:0]        rd_hit;
  logic              flag_clr;
  logic              rst_start;

  ssw_evt_if evt ();

  // pin level and edge select into the detector
  assign evt.pin_level = field_detect_in;
  assign evt.edge_sel  = edge_sel_reg;

  ssw_edge_det u_edge (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .evt     (evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // supply select and pin status

  // low input picks secondary, high or pulled-up picks primary
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_sec_reg          <= 1'b0;
      detect_level_inv_reg <= 1'b0;
      pullup_reg           <= 1'b1; // pull-up stays on so the pin never floats
    end else begin
      sel_sec_reg          <= ~field_detect_in;
      detect_level_inv_reg <= ~field_detect_in;
      pullup_reg           <= 1'b1;
    end
  end

  assign sel_secondary_supply   = sel_sec_reg;
  assign field_detect_pullup_en = pullup_reg;

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
  assign wr_fire       = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr_hit        = ssw_decode(awaddr_reg);

  // address and data captured in either order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb0_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // write response, error on unmapped address
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_hit == 4'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // software registers, low byte lane only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edge_sel_reg   <= EDGE_SEL_RST;
      switch_key_reg <= KEY_RST;
    end else if (wr_fire && wstrb0_reg) begin
      if (wr_hit[0]) begin
        edge_sel_reg <= wdata_reg[1:0];
      end
      if (wr_hit[1]) begin
        switch_key_reg <= wdata_reg[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request flag

  assign flag_clr = wr_fire & wstrb0_reg & wr_hit[3] & wdata_reg[0];

  // set by a selected edge, cleared by writing one; set wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (evt.trig) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  assign pwr_sw_irq_flag = flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  assign s_axi_arready = ~rvalid_reg;
  assign rd_hit        = ssw_decode(s_axi_araddr);

  // read data captured at address handshake
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= (rd_hit == 4'h0) ? RESP_SLVERR : RESP_OKAY;
      rdata_reg  <= {24'h000000,
                     ({8{rd_hit[0]}} & {6'h00, edge_sel_reg}) |
                     ({8{rd_hit[1]}} & switch_key_reg) |
                     ({8{rd_hit[2]}} & {7'h00, detect_level_inv_reg}) |
                     ({8{rd_hit[3]}} & {7'h00, flag_reg})};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reset delay sequencer

  assign rst_start = evt.rise & (switch_key_reg != KEY_DISABLE)
                     & fast_internal_osc_on;

  // count out the delay then request a chip reset for one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dly_state_reg <= DLY_IDLE;
      dly_cnt_reg   <= '0;
    end else begin
      case (dly_state_reg)
        DLY_IDLE: begin
          dly_cnt_reg <= '0;
          if (rst_start) begin
            dly_state_reg <= DLY_COUNT;
          end
        end
        DLY_COUNT: begin
          if (dly_cnt_reg == DLY_LAST) begin
            dly_state_reg <= DLY_FIRE;
          end else begin
            dly_cnt_reg <= dly_cnt_reg + 9'h001;
          end
        end
        DLY_FIRE: begin
          dly_state_reg <= DLY_IDLE;
        end
        default: begin
          dly_state_reg <= DLY_IDLE;
        end
      endcase
    end
  end

  assign mcu_reset_req = (dly_state_reg == DLY_FIRE);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_sel_secondary;
    @(posedge clk_sys) disable iff (!rst_n)
      !field_detect_in |=> sel_secondary_supply;
  endproperty
  a_sel_secondary: assert property (p_sel_secondary) else $error("secondary not chosen");

  property p_sel_primary;
    @(posedge clk_sys) disable iff (!rst_n)
      field_detect_in |=> !sel_secondary_supply && field_detect_pullup_en;
  endproperty
  a_sel_primary: assert property (p_sel_primary) else $error("primary not chosen");

  property p_pin_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_PIN && $stable(field_detect_in))
      |=> s_axi_rvalid && (s_axi_rdata[0] == !$past(field_detect_in))
          && (s_axi_rdata[31:1] == '0);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin status not inverted");

  property p_key_blocks;
    @(posedge clk_sys) disable iff (!rst_n)
      (dly_state_reg == DLY_IDLE && switch_key_reg == KEY_DISABLE) |=> dly_state_reg == DLY_IDLE;
  endproperty
  a_key_blocks: assert property (p_key_blocks) else $error("reset despite disable key");

  property p_reset_delay;
    @(posedge clk_sys) disable iff (!rst_n)
      (dly_state_reg == DLY_IDLE && rst_start) |=> !mcu_reset_req ##RST_CYC_WAIT mcu_reset_req;
  endproperty
  a_reset_delay: assert property (p_reset_delay) else $error("reset delay wrong");

  property p_osc_off;
    @(posedge clk_sys) disable iff (!rst_n)
      (dly_state_reg == DLY_IDLE && !fast_internal_osc_on) |=> dly_state_reg == DLY_IDLE;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("reset with oscillator off");

  property p_flag_sticky;
    @(posedge clk_sys) disable iff (!rst_n)
      (pwr_sw_irq_flag && !flag_clr) |=> pwr_sw_irq_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_flag_set;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.trig |=> pwr_sw_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");
endmodule : ssw_ctrl
`default_nettype wire

// ==== rtl/ssw_pkg.sv ====
package ssw_pkg;
  // clock and reset delay timing
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          RST_DELAY_NS   = 1000;
  localparam int          RST_DELAY_CYC  = (RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DLY_W          = 9;
  localparam logic [8:0]  DLY_LAST       = 9'(RST_DELAY_CYC - 1);
  // register bus geometry
  localparam int          AXI_AW         = 12;
  localparam int          AXI_DW         = 32;
  // register byte offsets
  localparam logic [11:0] OFS_EDGE       = 12'h000;
  localparam logic [11:0] OFS_KEY        = 12'h004;
  localparam logic [11:0] OFS_PIN        = 12'h008;
  localparam logic [11:0] OFS_FLAG       = 12'h00C;
  // edge select encodings and reset value
  localparam logic [1:0]  EDGE_OFF       = 2'h0;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;
  localparam logic [1:0]  EDGE_SEL_RST   = 2'h0;
  // switch key byte values
  localparam logic [7:0]  KEY_DISABLE    = 8'hAA;
  localparam logic [7:0]  KEY_RST        = 8'h55;
  // bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // reset delay sequencer states
  typedef enum logic [2:0] {
    DLY_IDLE  = 3'b001,
    DLY_COUNT = 3'b010,
    DLY_FIRE  = 3'b100
  } ssw_dly_state_t;
endpackage : ssw_pkg

// ==== rtl/ssw_evt_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ssw_evt_if;
  logic       pin_level;
  logic [1:0] edge_sel;
  logic       rise;
  logic       fall;
  logic       trig;
  // detector side
  modport det (input pin_level, input edge_sel, output rise, output fall, output trig);
  // controller side
  modport ctl (output pin_level, output edge_sel, input rise, input fall, input trig);
endinterface : ssw_evt_if
`default_nettype wire

// ==== rtl/ssw_edge_det.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssw_edge_det (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // event carrier
  ssw_evt_if.det    evt
);
  import ssw_pkg::*;

  logic prev_reg;

  // previous level, starts high as the pull-up holds it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= evt.pin_level;
    end
  end

  // edge pulses and selected trigger
  assign evt.rise = evt.pin_level & ~prev_reg;
  assign evt.fall = ~evt.pin_level & prev_reg;
  assign evt.trig = (evt.edge_sel[0] & evt.rise) | (evt.edge_sel[1] & evt.fall);

  property p_rise_trig;
    @(posedge clk_sys) disable iff (!rst_n)
      (evt.edge_sel == EDGE_RISE && $rose(evt.pin_level)) |-> evt.trig;
  endproperty
  a_rise_trig: assert property (p_rise_trig) else $error("rising edge missed");

  property p_fall_trig;
    @(posedge clk_sys) disable iff (!rst_n)
      (evt.edge_sel == EDGE_FALL && $fell(evt.pin_level)) |-> evt.trig;
  endproperty
  a_fall_trig: assert property (p_fall_trig) else $error("falling edge missed");

  property p_wrong_edge;
    @(posedge clk_sys) disable iff (!rst_n)
      (evt.edge_sel == EDGE_RISE && $fell(evt.pin_level)) |-> !evt.trig;
  endproperty
  a_wrong_edge: assert property (p_wrong_edge) else $error("trigger on wrong edge");

  property p_off_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      (evt.edge_sel == EDGE_OFF) |-> !evt.trig;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("trigger while disabled");
endmodule : ssw_edge_det
`default_nettype wire

// ==== tb/ssw_nfc_tag_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssw_nfc_tag_model (
  // clock
  input  wire logic clk_sys,
  // field presence from the bench
  input  wire logic field_on,
  // pin side
  input  wire logic pullup_en,
  output logic      fd_level
);
  logic last_q = 1'b1;
  // open-drain pull-down; a released line goes high through the pull-up, or toggles each clock without it
  always_comb begin
    if (field_on) fd_level = 1'b0;
    else if (pullup_en) fd_level = 1'b1;
    else fd_level = ~last_q;
  end
  // last level, so an unheld line drifts instead of keeping its value
  always_ff @(posedge clk_sys) begin
    last_q <= fd_level;
  end
endmodule : ssw_nfc_tag_model
`default_nettype wire

// ==== tb/supply_source_switch_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module supply_source_switch_ctrl_tb;
  import ssw_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        field_on = 1'b0;
  logic        osc_on = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  logic [31:0] rdata, rd_data;
  logic        fd_level, sel_sec, pullup_en, rst_req, irq_flag;
  logic [7:0]  keys [5] = '{KEY_DISABLE, KEY_RST, 8'h00, 8'hAB, KEY_RST};
  int          bad_count = 0;
  int          checks = 0;
  int          n;

  // free-running system clock
  always #2 clk_sys = ~clk_sys;

  ssw_nfc_tag_model u_tag (.clk_sys(clk_sys), .field_on(field_on),
    .pullup_en(pullup_en), .fd_level(fd_level));

  ssw_ctrl u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .field_detect_in(fd_level),
    .fast_internal_osc_on(osc_on), .sel_secondary_supply(sel_sec),
    .field_detect_pullup_en(pullup_en), .mcu_reset_req(rst_req),
    .pwr_sw_irq_flag(irq_flag));

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // axi4-lite write, address and data offered together
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw, pb, ta, tw, tk;
    int   k;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    k = 0;
    while (pb && k < 100) begin
      @(negedge clk_sys);
      ta = pa & awready;
      tw = pw & wready;
      tk = pb & bvalid;
      wr_resp = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) bready <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
      pb = pb & ~tk;
      k++;
    end
    if (pb) chk("write done", 1, 0);
  endtask : bus_wr

  // axi4-lite read
  task automatic bus_rd(input logic [11:0] a);
    logic pa, pr, ta, tr;
    int   k;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    pr = 1'b1;
    k = 0;
    while (pr && k < 100) begin
      @(negedge clk_sys);
      ta = pa & arready;
      tr = pr & rvalid;
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      pa = pa & ~ta;
      pr = pr & ~tr;
      k++;
    end
    if (pr) chk("read done", 1, 0);
  endtask : bus_rd

  // move the field, then settle to a falling clock edge
  task automatic pin(input logic v);
    @(posedge clk_sys);
    field_on <= v;
    repeat (3) @(negedge clk_sys);
  endtask : pin

  // release the line and count edges until the reset pulse
  task automatic rise_gap(output int g);
    @(posedge clk_sys);
    field_on <= 1'b0;
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
      @(negedge clk_sys);
    end while (!rst_req && g < 400);
  endtask : rise_gap

  // verdict
  task automatic end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end

  // test sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("pullup", 1, pullup_en);
    chk("supply idle", 0, sel_sec);
    bus_rd(OFS_EDGE);
    chk("edge reset", {30'h0, EDGE_SEL_RST}, rd_data);
    bus_rd(OFS_KEY);
    chk("key reset", {24'h0, KEY_RST}, rd_data);
    bus_rd(OFS_PIN);
    chk("pin high", 0, rd_data);
    // field present, then gone
    pin(1'b1);
    chk("supply field", 1, sel_sec);
    bus_rd(OFS_PIN);
    chk("pin low", 1, rd_data);
    pin(1'b0);
    chk("supply no field", 0, sel_sec);
    // every edge mode, oscillator off so no reset
    for (int m = 0; m < 4; m++) begin
      bus_wr(OFS_EDGE, 32'(m));
      bus_wr(OFS_FLAG, 32'h1);
      pin(1'b1);
      chk("flag fall", 32'(m[1]), irq_flag);
      bus_rd(OFS_FLAG);
      chk("flag reg", 32'(m[1]), rd_data);
      bus_wr(OFS_FLAG, 32'h1);
      @(negedge clk_sys);
      chk("flag clear", 0, irq_flag);
      pin(1'b0);
      chk("flag rise", 32'(m[0]), irq_flag);
    end
    bus_wr(OFS_EDGE, {30'h0, EDGE_FALL});
    // key values and oscillator against the rising-edge reset
    for (int i = 0; i < 5; i++) begin
      bus_wr(OFS_KEY, {24'h0, keys[i]});
      osc_on <= (i != 4);
      pin(1'b1);
      rise_gap(n);
      chk("reset gap", (i == 0 || i == 4) ? 400 : RST_DELAY_CYC + 1, n);
      @(negedge clk_sys);
      chk("reset pulse", 0, rst_req);
    end
    // read-only and unmapped places
    bus_wr(OFS_PIN, 32'h1);
    chk("ro write", RESP_OKAY, wr_resp);
    // write without the low byte lane leaves the key alone
    wstrb <= 4'hE;
    bus_wr(OFS_KEY, {24'h0, KEY_DISABLE});
    wstrb <= 4'hF;
    chk("strb resp", RESP_OKAY, wr_resp);
    bus_rd(OFS_KEY);
    chk("strb key", {24'h0, KEY_RST}, rd_data);
    bus_rd(12'h010);
    chk("unmapped rd", RESP_SLVERR, rd_resp);
    chk("unmapped data", 0, rd_data);
    bus_wr(12'h010, 32'h1);
    chk("unmapped wr", RESP_SLVERR, wr_resp);
    // mid-run reset returns flag and edge select to defaults
    chk("flag before reset", 1, irq_flag);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("flag after reset", 0, irq_flag);
    chk("supply after reset", 0, sel_sec);
    bus_rd(OFS_EDGE);
    chk("edge after reset", {30'h0, EDGE_SEL_RST}, rd_data);
    end_of_test();
  end
endmodule : supply_source_switch_ctrl_tb
`default_nettype wire
